//--- bench/bus_side.sv
/*
  Bus logic on one port: drives only where the device does not, else floats.
  Assumes the bench sets the drive value and enable on clock edges.
*/
`timescale 1ns/1ps
module bus_side (
  input wire logic clk,
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe,
  input wire logic [7:0] ext_val,
  input wire logic ext_en,
  output logic [7:0] wire_lvl
);
  logic [7:0] last_q = 8'h00;
  // A floating wire shows the inverse of its last level, never a kind value
  always_ff @(posedge clk) begin
    last_q <= wire_lvl;
  end
  // Device wins each bit it drives, so own drive is read back
  assign wire_lvl = (dev_oe & dev_out) | (~dev_oe & (ext_en ? ext_val : ~last_q));
endmodule

//--- bench/testbench.sv
/*
  Self-checking bench: pins, bus logic on both ports and Avalon-MM accesses.
  Assumes the checker is bound to the top and bus_side models the port logic.
*/
`timescale 1ns/1ps
module testbench
  import xcvr_pkg::*;
;
  logic clk = 0, rstn = 0, fck = 0, rck = 0, fce = 1, rce = 1, fde = 1, rde = 1, le = 0, re = 0, rd = 0, wr = 0;
  logic [7:0] lv = 8'h00, rv = 8'h00, lin, rin, lout, loe, rout, roe;
  logic [3:0] addr = 4'h0, be = 4'hF;
  logic [31:0] wdata = 32'h0, rdata, q;
  logic wreq;
  int fail_count = 0, check_count = 0, cyc = 0;
  always #20 clk = ~clk;
  bus_side lside (.clk(clk), .dev_out(lout), .dev_oe(loe), .ext_val(lv), .ext_en(le), .wire_lvl(lin));
  bus_side rside (.clk(clk), .dev_out(rout), .dev_oe(roe), .ext_val(rv), .ext_en(re), .wire_lvl(rin));
  dual_octal_registered_transceiver uut (.clk(clk), .rstn(rstn), .fwd_capture_clock(fck), .rev_capture_clock(rck),
    .fwd_capture_enable_n(fce), .rev_capture_enable_n(rce), .fwd_drive_enable_n(fde), .rev_drive_enable_n(rde),
    .left_port_bits_in(lin), .left_port_bits_out(lout), .left_port_bits_oe(loe), .right_port_bits_in(rin),
    .right_port_bits_out(rout), .right_port_bits_oe(roe), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq));
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w; wr <= w; addr <= a; wdata <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 0; wr <= 0;
  endtask
  task drv(input logic f, input logic r);
    @(posedge clk);
    fde <= f; rde <= r;
    repeat (5) @(posedge clk);
  endtask
  // Source and enable settle well before the pin edge and stay after it
  task cap(input logic rev, input logic [7:0] d, input logic en_n);
    @(posedge clk);
    if (rev) begin rv <= d; re <= 1; rce <= en_n; end else begin lv <= d; le <= 1; fce <= en_n; end
    repeat (4) @(posedge clk);
    if (rev) rck <= 1; else fck <= 1;
    repeat (8) @(posedge clk);
    fck <= 0; rck <= 0; fce <= 1; rce <= 1; le <= 0; re <= 0;
    repeat (4) @(posedge clk);
  endtask
  // Right after reset nothing has been captured and both drivers are off
  task t_reset;
    bus(0, STATUS_OFFSET, 0); chk("status after reset", q, 32'h0000_0030);
    chk("no drive after reset", {roe, loe}, 16'h0000);
    $display("reset test done");
  endtask
  task t_dirs;
    drv(0, 1); cap(0, 8'hA5, 0);
    chk("right out", rout, 8'hA5);
    chk("right wire", rin, 8'hA5);
    chk("enables fwd", {roe, loe}, 16'hFF00);
    cap(0, 8'h5A, 1);
    chk("right held", rout, 8'hA5);
    drv(1, 0); cap(1, 8'h3C, 0);
    chk("left wire", lin, 8'h3C);
    chk("enables rev", {roe, loe}, 16'h00FF);
    $display("direction test done");
  endtask
  task t_both;
    drv(1, 1); cap(0, 8'h0F, 0);
    chk("both off", {roe, loe}, 16'h0000);
    drv(0, 1);
    chk("loaded while off", rin, 8'h0F);
    cap(0, 8'hF0, 0);
    chk("load while driving", rin, 8'hF0);
    cap(1, 8'h77, 0);
    chk("own drive read back", lout, 8'hF0);
    $display("both-off and live test done");
  endtask
  task t_regs;
    bus(0, COUNT_OFFSET, 0); chk("counts", q, 32'h0002_0003);
    bus(0, STORE_OFFSET, 0); chk("stores", q, 32'h0000_F0F0);
    bus(1, CTRL_OFFSET, 0); repeat (4) @(posedge clk);
    chk("drive blocked", roe, 8'h00);
    bus(1, CTRL_OFFSET, 32'h3); repeat (4) @(posedge clk);
    bus(0, STATUS_OFFSET, 0); chk("status", q, 32'h0000_0027);
    bus(0, 4'h2, 0); chk("unmapped", q, 32'h0);
    be <= 4'h3; bus(1, COUNT_OFFSET, 0); bus(0, COUNT_OFFSET, 0); chk("fwd cleared", q, 32'h0002_0000);
    be <= 4'hF; bus(1, COUNT_OFFSET, 0); bus(0, COUNT_OFFSET, 0); chk("cleared", q, 32'h0);
    $display("register test done");
  endtask
  // Cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1;
    t_reset(); t_dirs(); t_both(); t_regs();
    end_of_test();
  end
endmodule

//--- bench/xcvr_checker.sv
/*
  Port assertions for the dual octal registered transceiver.
  Assumes pin stimulus is held stable for several clocks around each capture edge.
*/
`timescale 1ns/1ps
module xcvr_checker
  import xcvr_pkg::*;
#(
  parameter int W = PORT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic fwd_capture_clock,
  input wire logic rev_capture_clock,
  input wire logic fwd_capture_enable_n,
  input wire logic rev_capture_enable_n,
  input wire logic fwd_drive_enable_n,
  input wire logic rev_drive_enable_n,
  input wire logic [W-1:0] left_port_bits_in,
  input wire logic [W-1:0] left_port_bits_out,
  input wire logic [W-1:0] left_port_bits_oe,
  input wire logic [W-1:0] right_port_bits_in,
  input wire logic [W-1:0] right_port_bits_out,
  input wire logic [W-1:0] right_port_bits_oe,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  // One clock domain, so one clocking and one reset for all
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Sync chain plus store take three samples; checking at five leaves margin
  fwd_capture_a: assert property ($rose(fwd_capture_clock) && !fwd_capture_enable_n |-> ##5
    right_port_bits_out == $past(left_port_bits_in, 5)) else $error("forward store missed data");
  rev_capture_a: assert property ($rose(rev_capture_clock) && !rev_capture_enable_n |-> ##5
    left_port_bits_out == $past(right_port_bits_in, 5)) else $error("reverse store missed data");
  fwd_hold_a: assert property (fwd_capture_enable_n [*6] |-> $stable(right_port_bits_out))
    else $error("forward store changed while disabled");
  fwd_off_a: assert property (fwd_drive_enable_n [*4] |-> right_port_bits_oe == '0)
    else $error("right port driven while disabled");
  rev_off_a: assert property (rev_drive_enable_n [*4] |-> left_port_bits_oe == '0)
    else $error("left port driven while disabled");
  oe_whole_a: assert property ((&right_port_bits_oe || !(|right_port_bits_oe))
    && (&left_port_bits_oe || !(|left_port_bits_oe))) else $error("port enables split");
  fwd_oe_cause_a: assert property (|right_port_bits_oe |->
    !$past(fwd_drive_enable_n, 2) || !$past(fwd_drive_enable_n, 3)) else $error("right drive without cause");
  ack_once_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer held too long");
  ack_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("answer late");
  // Main scenarios reached
  cover property ($rose(fwd_capture_clock) && !fwd_capture_enable_n);
  cover property ($rose(rev_capture_clock) && !rev_capture_enable_n);
  cover property (avs_read && !avs_waitrequest);
endmodule

bind dual_octal_registered_transceiver xcvr_checker #(.W(W)) chk_i (.clk, .rstn, .fwd_capture_clock,
  .rev_capture_clock, .fwd_capture_enable_n, .rev_capture_enable_n, .fwd_drive_enable_n, .rev_drive_enable_n,
  .left_port_bits_in, .left_port_bits_out, .left_port_bits_oe, .right_port_bits_in, .right_port_bits_out,
  .right_port_bits_oe, .avs_read, .avs_write, .avs_waitrequest);

//--- src/capture_lane.sv
/*
  One transfer direction: synchronises its capture clock, capture enable,
  drive enable and source bits, stores the source on a qualified rising
  capture clock edge and drives the stored bits out while enabled.
  Assumes the pin clock is slow against clk (high and low each >= 3 clk periods).
*/
`timescale 1ns/1ps
module capture_lane
  import xcvr_pkg::*;
#(
  parameter int W = PORT_W
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cap_clk,
  input wire logic cap_en_n,
  input wire logic drv_en_n,
  input wire logic drive_allow,
  input wire logic [W-1:0] src,
  output logic [W-1:0] store_q,
  output logic loaded_q,
  output logic capture_q,
  output logic drive_q,
  output logic drv_en_n_q
);

  logic clk_s1_q, clk_s2_q, clk_s3_q;
  logic en_s1_q, en_s2_q;
  logic drv_s1_q;
  logic [W-1:0] src_s1_q, src_s2_q;
  logic capture_d;

  // Two-stage synchronisers; first stages are read only by second stages
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      en_s1_q <= 1'b1;
      en_s2_q <= 1'b1;
      drv_s1_q <= 1'b1;
      drv_en_n_q <= 1'b1;
      src_s1_q <= STORE_RESET;
      src_s2_q <= STORE_RESET;
    end else begin
      clk_s1_q <= cap_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q; // Edge history for the detector
      en_s1_q <= cap_en_n;
      en_s2_q <= en_s1_q;
      drv_s1_q <= drv_en_n;
      drv_en_n_q <= drv_s1_q;
      src_s1_q <= src;
      src_s2_q <= src_s1_q;
    end
  end

  // Rising capture edge with enable low; drive state plays no part
  assign capture_d = clk_s2_q && !clk_s3_q && !en_s2_q;

  // Storage register: loads uninverted on a qualified edge, holds otherwise
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      store_q <= STORE_RESET; // Software must not rely on this value
    end else if (capture_d) begin
      store_q <= src_s2_q;
    end
  end // Holds when enable is high or no edge arrives

  // Loaded flag shows whether the store has ever captured since reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loaded_q <= 1'b0;
    end else if (capture_d) begin
      loaded_q <= 1'b1;
    end
  end

  // One-cycle capture pulse for the counters
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capture_q <= 1'b0;
    end else begin
      capture_q <= capture_d;
    end
  end

  // Drivers on only while the drive enable pin is low and software allows
  // Reads the second sync stage, so the drivers follow the pin three clocks late
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= !drv_en_n_q && drive_allow;
    end
  end

endmodule

//--- src/dual_octal_registered_transceiver.sv
/*
  Top of the dual octal registered transceiver: two capture lanes (forward
  left to right, reverse right to left), split bidirectional ports and an
  Avalon-MM slave with control, status, store and counter registers.
  Assumes the surroundings resolve each port wire from out/oe and feed the
  resolved level back on the matching input; all pin inputs are asynchronous.

*/
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module dual_octal_registered_transceiver
  import xcvr_pkg::*;
#(
  parameter int W = PORT_W
) (
  input wire logic clk,
  input wire logic rstn,
  // Capture and drive controls, active low enables
  input wire logic fwd_capture_clock,
  input wire logic rev_capture_clock,
  input wire logic fwd_capture_enable_n,
  input wire logic rev_capture_enable_n,
  input wire logic fwd_drive_enable_n,
  input wire logic rev_drive_enable_n,
  // Left port split into level seen, level driven and enable
  input wire logic [W-1:0] left_port_bits_in,
  output logic [W-1:0] left_port_bits_out,
  output logic [W-1:0] left_port_bits_oe,
  // Right port split the same way
  input wire logic [W-1:0] right_port_bits_in,
  output logic [W-1:0] right_port_bits_out,
  output logic [W-1:0] right_port_bits_oe,
  // Avalon-MM slave
  input wire logic [BUS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [BUS_DATA_W-1:0] avs_writedata,
  input wire logic [BUS_BE_W-1:0] avs_byteenable,
  output logic [BUS_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest
);

  logic [DIR_N-1:0] lane_clk, lane_en_n, lane_drv_n, lane_allow;
  logic [DIR_N-1:0] lane_loaded, lane_capture, lane_drive, lane_drv_n_q;
  logic [W-1:0] lane_src [DIR_N];
  logic [W-1:0] lane_store [DIR_N];
  logic [COUNT_W-1:0] count_q [DIR_N];
  logic [1:0] ctrl_q;
  logic bus_req, bus_take, bus_wr;

  // Lane wiring: forward reads the left port, reverse reads the right port
  assign lane_clk = {rev_capture_clock, fwd_capture_clock};
  assign lane_en_n = {rev_capture_enable_n, fwd_capture_enable_n};
  assign lane_drv_n = {rev_drive_enable_n, fwd_drive_enable_n};
  assign lane_allow = {ctrl_q[CTRL_REV_ALLOW_BIT], ctrl_q[CTRL_FWD_ALLOW_BIT]};
  assign lane_src[DIR_FWD] = left_port_bits_in;
  assign lane_src[DIR_REV] = right_port_bits_in;

  // The two directions are identical, so one lane per direction
  for (genvar d = 0; d < DIR_N; d++) begin : g_lane
    capture_lane #(
      .W(W)
    ) u_lane (
      .clk(clk),
      .rstn(rstn),
      .cap_clk(lane_clk[d]),
      .cap_en_n(lane_en_n[d]),
      .drv_en_n(lane_drv_n[d]),
      .drive_allow(lane_allow[d]),
      .src(lane_src[d]),
      .store_q(lane_store[d]),
      .loaded_q(lane_loaded[d]),
      .capture_q(lane_capture[d]),
      .drive_q(lane_drive[d]),
      .drv_en_n_q(lane_drv_n_q[d])
    );
  end

  // Port outputs come straight from the store flops, uninverted
  assign right_port_bits_out = lane_store[DIR_FWD];
  assign left_port_bits_out = lane_store[DIR_REV];

  // Every bit of a port shares its lane's drive flop
  assign right_port_bits_oe = {W{lane_drive[DIR_FWD]}};
  assign left_port_bits_oe = {W{lane_drive[DIR_REV]}};

  // A request is answered one cycle after it is first seen
  assign bus_req = avs_read || avs_write;
  assign bus_take = bus_req && avs_waitrequest;
  assign bus_wr = avs_write && !avs_waitrequest;

  // Waitrequest drops for exactly one cycle per request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !bus_take;
    end
  end

  // Read mux: loaded while waitrequest falls so data stands at the taking edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= READ_RESET;
    end else if (bus_take && avs_read) begin
      avs_readdata <= READ_RESET;
      unique case (avs_address)
        CTRL_OFFSET: begin
          avs_readdata[CTRL_FWD_ALLOW_BIT] <= ctrl_q[CTRL_FWD_ALLOW_BIT];
          avs_readdata[CTRL_REV_ALLOW_BIT] <= ctrl_q[CTRL_REV_ALLOW_BIT];
        end
        STATUS_OFFSET: begin
          avs_readdata[STAT_FWD_LOADED_BIT] <= lane_loaded[DIR_FWD];
          avs_readdata[STAT_REV_LOADED_BIT] <= lane_loaded[DIR_REV];
          avs_readdata[STAT_FWD_DRIVE_BIT] <= lane_drive[DIR_FWD];
          avs_readdata[STAT_REV_DRIVE_BIT] <= lane_drive[DIR_REV];
          avs_readdata[STAT_FWD_ENABLE_N_BIT] <= lane_drv_n_q[DIR_FWD];
          avs_readdata[STAT_REV_ENABLE_N_BIT] <= lane_drv_n_q[DIR_REV];
        end
        STORE_OFFSET: begin
          avs_readdata[STORE_FWD_LSB +: W] <= lane_store[DIR_FWD];
          avs_readdata[STORE_REV_LSB +: W] <= lane_store[DIR_REV];
        end
        COUNT_OFFSET: begin
          avs_readdata[COUNT_FWD_LSB +: COUNT_W] <= count_q[DIR_FWD];
          avs_readdata[COUNT_REV_LSB +: COUNT_W] <= count_q[DIR_REV];
        end
        default: begin
          avs_readdata <= READ_RESET; // Unmapped offsets read as zero
        end
      endcase
    end
  end

  // Control: byte lane 0 only; lets software quiet either driver set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RESET;
    end else if (bus_wr && avs_address == CTRL_OFFSET && avs_byteenable[0]) begin
      ctrl_q <= avs_writedata[1:0];
    end
  end

  // Capture counters wrap; a write with the counter's low byte lane enabled clears it, and a capture in that same cycle leaves the count at 1
  for (genvar d = 0; d < DIR_N; d++) begin : g_count
    localparam int LSB = (d == DIR_FWD) ? COUNT_FWD_LSB : COUNT_REV_LSB;
    logic clr;
    assign clr = bus_wr && avs_address == COUNT_OFFSET && avs_byteenable[LSB/8];
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        count_q[d] <= COUNT_RESET;
      end else if (clr && lane_capture[d]) begin
        count_q[d] <= COUNT_W'(1);
      end else if (clr) begin
        count_q[d] <= COUNT_RESET;
      end else if (lane_capture[d]) begin
        count_q[d] <= COUNT_W'(count_q[d] + COUNT_W'(1));
      end
    end
  end

endmodule

//--- src/xcvr_pkg.sv
/*
  Shared constants for the dual octal registered transceiver: port width,
  clock rate, bus geometry, register offsets, field positions and reset values.
  Assumes a 32-bit Avalon-MM slave with byte addressing on a 25 MHz clock.
*/
package xcvr_pkg;

  // Data path width of each port
  localparam int PORT_W = 8;

  // Clock of the register and sampling logic
  localparam int CLK_MHZ = 25;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;

  // Register bus geometry
  localparam int BUS_ADDR_W = 4;
  localparam int BUS_DATA_W = 32;
  localparam int BUS_BE_W = 4;

  // Register byte offsets
  localparam logic [BUS_ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [BUS_ADDR_W-1:0] STATUS_OFFSET = 4'h4;
  localparam logic [BUS_ADDR_W-1:0] STORE_OFFSET = 4'h8;
  localparam logic [BUS_ADDR_W-1:0] COUNT_OFFSET = 4'hC;

  // Control register fields
  localparam int CTRL_FWD_ALLOW_BIT = 0;
  localparam int CTRL_REV_ALLOW_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  // Status register fields
  localparam int STAT_FWD_LOADED_BIT = 0;
  localparam int STAT_REV_LOADED_BIT = 1;
  localparam int STAT_FWD_DRIVE_BIT = 2;
  localparam int STAT_REV_DRIVE_BIT = 3;
  localparam int STAT_FWD_ENABLE_N_BIT = 4;
  localparam int STAT_REV_ENABLE_N_BIT = 5;

  // Store register fields: forward store low byte, reverse store next byte
  localparam int STORE_FWD_LSB = 0;
  localparam int STORE_REV_LSB = 8;

  // Capture counters, one half word per direction
  localparam int COUNT_W = 16;
  localparam int COUNT_FWD_LSB = 0;
  localparam int COUNT_REV_LSB = 16;

  // Reset values
  localparam logic [PORT_W-1:0] STORE_RESET = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [BUS_DATA_W-1:0] READ_RESET = 32'h0000_0000;

  // Direction indices
  localparam int DIR_FWD = 0;
  localparam int DIR_REV = 1;
  localparam int DIR_N = 2;

endpackage
